/* hw/accel_pkg.sv */
// Function
// - Write: start, address, pointer, data, each acknowledged.
// - Controller keeps pointer byte top bit zero.
// - Device acknowledges each write data byte.
// - Written bytes land in pointed registers.
// - Pointer steps by one per written byte.
// - Read: pointer write, repeated start, read address.
// - Device sends register chosen by pointer.
// - Controller acknowledges all but last byte.
// - Pointer steps by one per read byte.
// - Bytes travel most significant bit first.
// - Target may stretch clock before sending; controller waits.
// - Clear operating mode before changing configuration.
// - Twelve or eight valid bits per resolution.
// - Outputs refresh once per output rate period.
// - No sample overwrite while outputs are read; a sample due in the cycle of the first data fetch still updates them.
// - Outputs are two's complement, full range.
// - Twelve-bit count scales with selected range.
// - Target address 000111 plus strap bit.
// - Low byte holds bits 3..0 in 7..4.
// - Selftest_control response 55, aa after command, clears on read.
package accel_pkg;
	localparam logic [7:0] REG_X_LOW = 8'h06;
	localparam logic [7:0] REG_X_HIGH = 8'h07;
	localparam logic [7:0] REG_Y_LOW = 8'h08;
	localparam logic [7:0] REG_Y_HIGH = 8'h09;
	localparam logic [7:0] REG_Z_LOW = 8'h0a;
	localparam logic [7:0] REG_Z_HIGH = 8'h0b;
	localparam logic [7:0] REG_SELFTEST_RESPONSE = 8'h0c;
	localparam logic [7:0] REG_DEVICE_IDENTITY = 8'h0f;
	localparam logic [7:0] REG_IRQ_SOURCE_PRIMARY = 8'h16;
	localparam logic [7:0] REG_IRQ_SOURCE_MOTION = 8'h17;
	localparam logic [7:0] REG_IRQ_SUMMARY = 8'h18;
	localparam logic [7:0] REG_IRQ_RELEASE = 8'h1a;
	localparam logic [7:0] REG_MAIN_CONTROL = 8'h1b;
	localparam logic [7:0] REG_AUX_CONTROL = 8'h1d;
	localparam logic [7:0] REG_IRQ_CONFIG_A = 8'h1e;
	localparam logic [7:0] REG_IRQ_CONFIG_B = 8'h1f;
	localparam logic [7:0] REG_OUTPUT_RATE_CONFIG = 8'h21;
	localparam logic [7:0] REG_MOTION_DELAY_COUNT = 8'h29;
	localparam logic [7:0] REG_SELFTEST_CONTROL = 8'h3a;
	localparam logic [7:0] REG_MOTION_LEVEL = 8'h6a;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	// Field positions.
	localparam int OPERATING_MODE_BIT = 7;
	localparam int RESOLUTION_BIT = 6;
	localparam int RANGE_LSB = 3;
	localparam int SELFTEST_COMMAND_BIT = 4;
	localparam int DRDY_FLAG_BIT = 4;
	localparam int RATE_CODE_W = 3;
	localparam logic [7:0] SELFTEST_IDLE = 8'h55;
	localparam logic [7:0] SELFTEST_DONE = 8'haa;
	localparam logic [5:0] TARGET_ADDRESS_FIXED = 6'b000111;
	// Timing.
	localparam int CLOCK_PERIOD_NS = 10;
	localparam int LINK_PERIOD_NS = 80;
	localparam int QUARTER_CYCLES = LINK_PERIOD_NS / (4 * CLOCK_PERIOD_NS);
	localparam int STRETCH_CYCLES = 4;
	localparam int RATE_BASE_CYCLES = 1600;
	// Controller command port.
	localparam logic [3:0] HOST_REG_POINTER = 4'h0;
	localparam logic [3:0] HOST_REG_LENGTH = 4'h1;
	localparam logic [3:0] HOST_REG_COMMAND = 4'h2;
	localparam logic [3:0] HOST_REG_STATUS = 4'h3;
	localparam logic [3:0] HOST_REG_BUFFER = 4'h8;
	localparam int CMD_GO_BIT = 0;
	localparam int CMD_READ_BIT = 1;
	localparam int CMD_STRAP_BIT = 2;
	localparam int HOST_DEPTH = 8;
endpackage

/* hw/accel_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface accel_link_if;
	logic host_scl_out;
	logic host_scl_oe_n;
	logic host_sda_out;
	logic host_sda_oe_n;
	logic dev_scl_out;
	logic dev_scl_oe_n;
	logic dev_sda_out;
	logic dev_sda_oe_n;
	logic scl;
	logic sda;
	// Open-drain wires with pull-up: low wins whenever a driver is enabled.
	assign scl = (host_scl_oe_n | host_scl_out) & (dev_scl_oe_n | dev_scl_out);
	assign sda = (host_sda_oe_n | host_sda_out) & (dev_sda_oe_n | dev_sda_out);
	modport device(input scl, input sda, output dev_scl_out, output dev_scl_oe_n, output dev_sda_out,
		output dev_sda_oe_n);
	modport host(input scl, input sda, output host_scl_out, output host_scl_oe_n, output host_sda_out,
		output host_sda_oe_n);
endinterface
`default_nettype wire

/* hw/accel_target.sv */
`timescale 1ns/10ps
`default_nettype none
module accel_target #(
	parameter logic [7:0] IDENTITY_CODE = 8'h3c, // Arbitrary value.
	parameter int RATE_BASE = accel_pkg::RATE_BASE_CYCLES
) (
	input wire logic clock,
	input wire logic reset_n,
	accel_link_if.device link,
	input wire logic addr_select,
	input wire logic signed [15:0] raw_x,
	input wire logic signed [15:0] raw_y,
	input wire logic signed [15:0] raw_z,
	output logic [7:0] main_control,
	output logic data_ready,
	output logic selftest_active
);
	import accel_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_PTR = 3'b010,
		ST_WR = 3'b011,
		ST_RD = 3'b100,
		ST_WAIT = 3'b101
	} tstate_t;

	tstate_t state_r;
	logic [1:0] scl_sync_r, sda_sync_r, strap_sync_r;
	logic scl_q_r, sda_q_r;
	logic scl_rise, scl_fall, bus_start, bus_stop;
	logic [3:0] cnt_r;
	logic [7:0] shift_r, register_pointer_r, rd_byte;
	logic rw_r, mack_r, sda_oe_n_r, scl_oe_n_r;
	logic [3:0] stretch_r;
	logic wr_fire, rd_fire;
	logic [7:0] aux_r, irq_a_r, irq_b_r, rate_r, delay_r, stctl_r, level_r;
	logic drdy_r, st_flag_r, lock_r, pending_r, update;
	logic [23:0] rate_timer_r, rate_period;
	logic [11:0] accel_r [3];
	logic signed [15:0] raw [3];

	// Saturating scale of a raw sample (1/8192 g) to 12-bit counts for the range.
	function automatic logic [11:0] scale(input logic signed [15:0] v, input logic [1:0] range);
		logic signed [15:0] s;
		s = (range == 2'h0) ? (v >>> 3) : (range == 2'h1) ? (v >>> 4) : (v >>> 5);
		if (s > 16'sd2047) begin
			scale = 12'h7ff;
		end else if (s < -16'sd2048) begin
			scale = 12'h800;
		end else begin
			scale = s[11:0];
		end
	endfunction

	// Low byte carries data bits 3..0 in its top nibble, empty in 8-bit mode.
	function automatic logic [7:0] low_byte(input logic [11:0] a, input logic res);
		low_byte = res ? {a[3:0], 4'h0} : 8'h00;
	endfunction

	function automatic logic is_data_reg(input logic [7:0] p);
		is_data_reg = (p >= REG_X_LOW) && (p <= REG_Z_HIGH);
	endfunction

	// Two-stage synchronisers for the link pins and the address strap.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			scl_sync_r <= 2'h3;
			sda_sync_r <= 2'h3;
			strap_sync_r <= 2'h0;
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_sync_r <= {scl_sync_r[0], link.scl};
			sda_sync_r <= {sda_sync_r[0], link.sda};
			strap_sync_r <= {strap_sync_r[0], addr_select};
			scl_q_r <= scl_sync_r[1];
			sda_q_r <= sda_sync_r[1];
		end
	end

	// Edge and bus condition detection on the synchronised pins.
	assign scl_rise = scl_sync_r[1] & ~scl_q_r;
	assign scl_fall = ~scl_sync_r[1] & scl_q_r;
	assign bus_start = scl_sync_r[1] & scl_q_r & sda_q_r & ~sda_sync_r[1];
	assign bus_stop = scl_sync_r[1] & scl_q_r & ~sda_q_r & sda_sync_r[1];
	assign wr_fire = (state_r == ST_WR) && scl_fall && (cnt_r == 4'd8);
	assign rd_fire = scl_fall && (cnt_r == 4'd9) && (((state_r == ST_ADDR) && rw_r) || ((state_r == ST_RD) && mack_r));

	// Byte-level target sequencer.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= ST_IDLE;
			cnt_r <= 4'h0;
			shift_r <= 8'h00;
			register_pointer_r <= 8'h00;
			rw_r <= 1'b0;
			mack_r <= 1'b0;
			sda_oe_n_r <= 1'b1;
		end else if (bus_start) begin
			state_r <= ST_ADDR;
			cnt_r <= 4'h0;
			sda_oe_n_r <= 1'b1;
		end else if (bus_stop) begin
			state_r <= ST_IDLE;
			sda_oe_n_r <= 1'b1;
		end else begin
			unique case (state_r)
				ST_ADDR, ST_PTR, ST_WR, ST_RD: begin
					if (scl_rise) begin
						cnt_r <= cnt_r + 4'd1;
						if (state_r != ST_RD && cnt_r < 4'd8) begin
							shift_r <= {shift_r[6:0], sda_sync_r[1]};
						end
						if (state_r == ST_RD && cnt_r == 4'd8) begin
							mack_r <= ~sda_sync_r[1];
						end
					end else if (scl_fall) begin
						if (cnt_r == 4'd8) begin
							if (state_r == ST_RD) begin
								sda_oe_n_r <= 1'b1;
								register_pointer_r <= register_pointer_r + 8'd1;
							end else if (state_r == ST_ADDR && shift_r[7:1] != {TARGET_ADDRESS_FIXED, strap_sync_r[1]}) begin
								state_r <= ST_IDLE;
							end else begin
								sda_oe_n_r <= 1'b0;
								if (state_r == ST_ADDR) begin
									rw_r <= shift_r[0];
								end
								if (state_r == ST_PTR) begin
									register_pointer_r <= shift_r;
								end
								if (state_r == ST_WR) begin
									register_pointer_r <= register_pointer_r + 8'd1;
								end
							end
						end else if (cnt_r == 4'd9) begin
							cnt_r <= 4'h0;
							if (rd_fire) begin
								state_r <= ST_RD;
								shift_r <= rd_byte;
								sda_oe_n_r <= rd_byte[7];
							end else begin
								sda_oe_n_r <= 1'b1;
								state_r <= (state_r == ST_ADDR) ? ST_PTR : (state_r == ST_RD) ? ST_WAIT : ST_WR;
							end
						end else if (state_r == ST_RD) begin
							sda_oe_n_r <= shift_r[6];
							shift_r <= {shift_r[6:0], 1'b0};
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Hold the clock low while the next outgoing byte is fetched.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			stretch_r <= 4'h0;
			scl_oe_n_r <= 1'b1;
		end else begin
			if (rd_fire) begin
				stretch_r <= 4'(STRETCH_CYCLES);
			end else if (stretch_r != 4'h0) begin
				stretch_r <= stretch_r - 4'd1;
			end
			scl_oe_n_r <= ~(rd_fire || stretch_r > 4'd1);
		end
	end

	// Register read multiplexer; reserved addresses read zero.
	always_comb begin
		unique case (register_pointer_r)
			REG_X_LOW: rd_byte = low_byte(accel_r[0], main_control[RESOLUTION_BIT]);
			REG_X_HIGH: rd_byte = accel_r[0][11:4];
			REG_Y_LOW: rd_byte = low_byte(accel_r[1], main_control[RESOLUTION_BIT]);
			REG_Y_HIGH: rd_byte = accel_r[1][11:4];
			REG_Z_LOW: rd_byte = low_byte(accel_r[2], main_control[RESOLUTION_BIT]);
			REG_Z_HIGH: rd_byte = accel_r[2][11:4];
			REG_SELFTEST_RESPONSE: rd_byte = st_flag_r ? SELFTEST_DONE : SELFTEST_IDLE;
			REG_DEVICE_IDENTITY: rd_byte = IDENTITY_CODE;
			REG_IRQ_SOURCE_PRIMARY, REG_IRQ_SUMMARY: rd_byte = 8'(drdy_r) << DRDY_FLAG_BIT;
			REG_MAIN_CONTROL: rd_byte = main_control;
			REG_AUX_CONTROL: rd_byte = aux_r;
			REG_IRQ_CONFIG_A: rd_byte = irq_a_r;
			REG_IRQ_CONFIG_B: rd_byte = irq_b_r;
			REG_OUTPUT_RATE_CONFIG: rd_byte = rate_r;
			REG_MOTION_DELAY_COUNT: rd_byte = delay_r;
			REG_SELFTEST_CONTROL: rd_byte = stctl_r;
			REG_MOTION_LEVEL: rd_byte = level_r;
			default: rd_byte = 8'h00;
		endcase
	end

	// Writable registers; writes elsewhere are dropped.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			main_control <= CONFIG_RESET;
			aux_r <= CONFIG_RESET;
			irq_a_r <= CONFIG_RESET;
			irq_b_r <= CONFIG_RESET;
			rate_r <= CONFIG_RESET;
			delay_r <= CONFIG_RESET;
			stctl_r <= CONFIG_RESET;
			level_r <= CONFIG_RESET;
		end else if (wr_fire) begin
			unique case (register_pointer_r)
				REG_MAIN_CONTROL: main_control <= shift_r;
				REG_AUX_CONTROL: aux_r <= shift_r;
				REG_IRQ_CONFIG_A: irq_a_r <= shift_r;
				REG_IRQ_CONFIG_B: irq_b_r <= shift_r;
				REG_OUTPUT_RATE_CONFIG: rate_r <= shift_r;
				REG_MOTION_DELAY_COUNT: delay_r <= shift_r;
				REG_SELFTEST_CONTROL: stctl_r <= shift_r;
				REG_MOTION_LEVEL: level_r <= shift_r;
				default: begin
				end
			endcase
		end
	end

	// Sticky flags: a set in the same cycle as a clearing read wins.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_flag_r <= 1'b0;
			drdy_r <= 1'b0;
		end else begin
			if (wr_fire && register_pointer_r == REG_SELFTEST_CONTROL && shift_r[SELFTEST_COMMAND_BIT]) begin
				st_flag_r <= 1'b1;
			end else if (rd_fire && register_pointer_r == REG_SELFTEST_RESPONSE) begin
				st_flag_r <= 1'b0;
			end
			if (update) begin
				drdy_r <= 1'b1;
			end else if (rd_fire && (is_data_reg(register_pointer_r) || register_pointer_r == REG_IRQ_RELEASE)) begin
				drdy_r <= 1'b0;
			end
		end
	end

	// Output lock from the first data read until the transfer ends.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			lock_r <= 1'b0;
		end else if (bus_start || bus_stop) begin
			lock_r <= 1'b0;
		end else if (rd_fire && is_data_reg(register_pointer_r)) begin
			lock_r <= 1'b1;
		end
	end

	// Output-rate timer; a sample due during a locked read waits for the unlock.
	assign rate_period = 24'(RATE_BASE) << rate_r[RATE_CODE_W-1:0];
	assign update = main_control[OPERATING_MODE_BIT] && !lock_r && (pending_r || rate_timer_r == 24'h0);
	assign raw[0] = raw_x;
	assign raw[1] = raw_y;
	assign raw[2] = raw_z;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rate_timer_r <= 24'h0;
			pending_r <= 1'b0;
		end else begin
			rate_timer_r <= (rate_timer_r == 24'h0) ? rate_period - 24'd1 : rate_timer_r - 24'd1;
			if (update) begin
				pending_r <= 1'b0;
			end else if (rate_timer_r == 24'h0 && main_control[OPERATING_MODE_BIT]) begin
				pending_r <= 1'b1;
			end
		end
	end

	// Per-axis output capture.
	for (genvar i = 0; i < 3; i++) begin : g_axis
		always_ff @(posedge clock or negedge reset_n) begin
			if (!reset_n) begin
				accel_r[i] <= 12'h000;
			end else if (update) begin
				accel_r[i] <= scale(raw[i], main_control[RANGE_LSB+1:RANGE_LSB]);
			end
		end
	end

	assign link.dev_sda_out = 1'b0;
	assign link.dev_scl_out = 1'b0;
	assign link.dev_sda_oe_n = sda_oe_n_r;
	assign link.dev_scl_oe_n = scl_oe_n_r;
	assign data_ready = drdy_r;
	assign selftest_active = st_flag_r;
endmodule
`default_nettype wire

/* hw/accel_controller.sv */
`timescale 1ns/10ps
`default_nettype none
module accel_controller #(
	parameter int QUARTER = accel_pkg::QUARTER_CYCLES
) (
	input wire logic clock,
	input wire logic reset_n,
	accel_link_if.host link,
	input wire logic [3:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	input wire logic cmd_write,
	input wire logic cmd_read,
	output logic [7:0] cmd_rdata
);
	import accel_pkg::*;

	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_START = 2'b01,
		H_BIT = 2'b10,
		H_STOP = 2'b11
	} hstate_t;
	typedef enum logic [2:0] {
		STG_ADDRW = 3'b000,
		STG_PTR = 3'b001,
		STG_WDATA = 3'b010,
		STG_ADDRR = 3'b011,
		STG_RDATA = 3'b100
	} stage_t;

	hstate_t state_r;
	stage_t stg_r;
	logic [1:0] scl_sync_r, sda_sync_r, ph_r;
	logic [7:0] qcnt_r, shift_r, register_pointer_r;
	logic [3:0] bit_r, len_r, idx_r;
	logic rd_r, strap_r, nack_r, scl_oe_n_r, sda_oe_n_r, sda_nxt;
	logic step, byte_done, is_rx, last;
	logic [7:0] buf_r [HOST_DEPTH];

	// Two-stage synchronisers for the link pins.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			scl_sync_r <= 2'h3;
			sda_sync_r <= 2'h3;
		end else begin
			scl_sync_r <= {scl_sync_r[0], link.scl};
			sda_sync_r <= {sda_sync_r[0], link.sda};
		end
	end

	// A phase ends after QUARTER cycles; phase 2, the first clock-high phase, also waits for the released line.
	assign step = (qcnt_r == 8'(QUARTER - 1)) && (ph_r != 2'd2 || scl_sync_r[1]);
	assign is_rx = (stg_r == STG_RDATA);
	assign last = (idx_r == len_r - 4'd1);
	assign byte_done = (state_r == H_BIT) && step && (ph_r == 2'd3) && (bit_r == 4'd8);

	// Data level per phase; phase 0 holds the old level so data never moves with the clock edge.
	always_comb begin
		sda_nxt = 1'b1;
		unique case (state_r)
			H_IDLE: sda_nxt = 1'b1;
			H_START: sda_nxt = (ph_r == 2'd0) ? sda_oe_n_r : (ph_r != 2'd3);
			H_STOP: sda_nxt = (ph_r == 2'd0) ? sda_oe_n_r : (ph_r == 2'd3);
			H_BIT: begin
				if (ph_r == 2'd0) begin
					sda_nxt = sda_oe_n_r;
				end else if (bit_r < 4'd8) begin
					sda_nxt = is_rx ? 1'b1 : shift_r[7];
				end else begin
					sda_nxt = is_rx ? last : 1'b1;
				end
			end
		endcase
	end

	// Registered open-drain enables.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			scl_oe_n_r <= 1'b1;
			sda_oe_n_r <= 1'b1;
		end else begin
			scl_oe_n_r <= (state_r == H_IDLE) | ph_r[1];
			sda_oe_n_r <= sda_nxt;
		end
	end

	// Transfer sequencer and command registers.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= H_IDLE;
			stg_r <= STG_ADDRW;
			ph_r <= 2'd0;
			qcnt_r <= 8'h00;
			bit_r <= 4'h0;
			shift_r <= 8'h00;
			idx_r <= 4'h0;
			register_pointer_r <= 8'h00;
			len_r <= 4'h1;
			rd_r <= 1'b0;
			strap_r <= 1'b0;
			nack_r <= 1'b0;
		end else if (state_r == H_IDLE) begin
			ph_r <= 2'd0;
			qcnt_r <= 8'h00;
			if (cmd_write && cmd_addr == HOST_REG_POINTER) begin
				register_pointer_r <= {1'b0, cmd_wdata[6:0]};
			end
			if (cmd_write && cmd_addr == HOST_REG_LENGTH) begin
				len_r <= (cmd_wdata[3:0] == 4'h0) ? 4'h1 : (cmd_wdata > 8'(HOST_DEPTH)) ? 4'(HOST_DEPTH) : cmd_wdata[3:0];
			end
			if (cmd_write && cmd_addr == HOST_REG_COMMAND && cmd_wdata[CMD_GO_BIT]) begin
				state_r <= H_START;
				stg_r <= STG_ADDRW;
				rd_r <= cmd_wdata[CMD_READ_BIT];
				strap_r <= cmd_wdata[CMD_STRAP_BIT];
				nack_r <= 1'b0;
				idx_r <= 4'h0;
			end
		end else begin
			qcnt_r <= step ? 8'h00 : (qcnt_r == 8'(QUARTER - 1)) ? qcnt_r : qcnt_r + 8'd1;
			if (step) begin
				ph_r <= ph_r + 2'd1;
			end
			if (step && ph_r == 2'd3) begin
				unique case (state_r)
					H_START: begin
						state_r <= H_BIT;
						bit_r <= 4'h0;
						shift_r <= {TARGET_ADDRESS_FIXED, strap_r, stg_r == STG_ADDRR};
					end
					H_STOP: state_r <= H_IDLE;
					H_BIT: begin
						bit_r <= bit_r + 4'd1;
						if (bit_r < 4'd8) begin
							shift_r <= {shift_r[6:0], is_rx ? sda_sync_r[1] : 1'b0};
						end else if (!is_rx && sda_sync_r[1]) begin
							nack_r <= 1'b1;
							state_r <= H_STOP;
						end else begin
							bit_r <= 4'h0;
							unique case (stg_r)
								STG_ADDRW: begin
									stg_r <= STG_PTR;
									shift_r <= register_pointer_r;
								end
								STG_PTR: begin
									stg_r <= rd_r ? STG_ADDRR : STG_WDATA;
									state_r <= rd_r ? H_START : H_BIT;
									shift_r <= buf_r[0];
								end
								STG_WDATA: begin
									idx_r <= idx_r + 4'd1;
									shift_r <= buf_r[3'(idx_r + 4'd1)];
									if (last) begin
										state_r <= H_STOP;
									end
								end
								STG_ADDRR: stg_r <= STG_RDATA;
								STG_RDATA: begin
									idx_r <= idx_r + 4'd1;
									if (last) begin
										state_r <= H_STOP;
									end
								end
								default: state_r <= H_STOP;
							endcase
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Data buffer: filled by software for writes and by the link for reads.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < HOST_DEPTH; i++) begin
				buf_r[i] <= 8'h00;
			end
		end else if (byte_done && is_rx) begin
			buf_r[idx_r[2:0]] <= shift_r;
		end else if (cmd_write && state_r == H_IDLE && cmd_addr >= HOST_REG_BUFFER) begin
			buf_r[cmd_addr[2:0]] <= cmd_wdata;
		end
	end

	// Read port: data stand for the one cycle after the strobe.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cmd_rdata <= 8'h00;
		end else if (cmd_read) begin
			unique case (cmd_addr)
				HOST_REG_POINTER: cmd_rdata <= register_pointer_r;
				HOST_REG_LENGTH: cmd_rdata <= {4'h0, len_r};
				HOST_REG_STATUS: cmd_rdata <= {6'h00, nack_r, state_r != H_IDLE};
				default: cmd_rdata <= (cmd_addr >= HOST_REG_BUFFER) ? buf_r[cmd_addr[2:0]] : 8'h00;
			endcase
		end else begin
			cmd_rdata <= 8'h00;
		end
	end

	assign link.host_scl_out = 1'b0;
	assign link.host_sda_out = 1'b0;
	assign link.host_scl_oe_n = scl_oe_n_r;
	assign link.host_sda_oe_n = sda_oe_n_r;
endmodule
`default_nettype wire

/* tb/accel_link_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module accel_link_assertions (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic host_scl_out,
	input wire logic host_scl_oe_n,
	input wire logic host_sda_out,
	input wire logic host_sda_oe_n,
	input wire logic dev_scl_out,
	input wire logic dev_scl_oe_n,
	input wire logic dev_sda_out,
	input wire logic dev_sda_oe_n,
	input wire logic scl,
	input wire logic sda
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	// Every line is released on leaving reset.
	property p_idle;
		$rose(reset_n) |-> host_scl_oe_n && host_sda_oe_n && dev_scl_oe_n && dev_sda_oe_n;
	endproperty
	a_idle: assert property (p_idle) else $error("line held at reset release");
	// Drivers may only pull low, never drive high.
	property p_open_drain;
		!(host_scl_out || host_sda_out || dev_scl_out || dev_sda_out);
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("line driven high");
	// The target moves the data line only while the clock is low.
	property p_dev_sda_low;
		$changed(dev_sda_oe_n) |-> !scl;
	endproperty
	a_dev_sda_low: assert property (p_dev_sda_low) else $error("target data moved with clock high");
	// Only the controller makes a start condition.
	property p_start_host;
		$fell(sda) && $past(scl) && scl |-> !host_sda_oe_n;
	endproperty
	a_start_host: assert property (p_start_host) else $error("start not made by controller");
	// A low clock phase of the controller lasts at least two cycles.
	property p_host_low;
		$fell(host_scl_oe_n) |=> !host_scl_oe_n;
	endproperty
	a_host_low: assert property (p_host_low) else $error("clock low phase too short");
	// The controller pulls the clock low only after seeing it high.
	property p_host_wait;
		$fell(host_scl_oe_n) |-> $past(scl) && $past(scl, 2);
	endproperty
	a_host_wait: assert property (p_host_wait) else $error("controller ignored stretched clock");
	// A stretch by the target is short and bounded.
	property p_stretch;
		$fell(dev_scl_oe_n) |-> ##[1:4] dev_scl_oe_n;
	endproperty
	a_stretch: assert property (p_stretch) else $error("clock stretch too long");
	// After a stop both lines stay high.
	property p_stop_free;
		$rose(sda) && $past(scl) && scl |=> (scl && sda) [*2];
	endproperty
	a_stop_free: assert property (p_stop_free) else $error("bus not free after stop");
	c_ack: cover property ($fell(dev_sda_oe_n));
	c_stretch: cover property ($fell(dev_scl_oe_n));
	c_stop: cover property ($rose(sda) && scl);
endmodule
`default_nettype wire

/* tb/tb_accel_i2c_register_port.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; $display("mismatch %0t got %h exp %h", $time, g, e); end end
module tb_accel_i2c_register_port;
	import accel_pkg::*;
	localparam logic [7:0] IDENT = 8'h5a; // Arbitrary value.
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic addr_select = 1'b0;
	logic signed [15:0] raw_x = '0;
	logic signed [15:0] raw_y = '0;
	logic signed [15:0] raw_z = '0;
	logic [3:0] cmd_addr = '0;
	logic [7:0] cmd_wdata = '0;
	logic cmd_write = 1'b0;
	logic cmd_read = 1'b0;
	logic [7:0] cmd_rdata;
	logic [7:0] main_control;
	logic data_ready;
	logic selftest_active;
	logic [7:0] buf_q [8];
	int fail_count = 0;
	int num_checks = 0;
	accel_link_if link ();
	accel_target #(.IDENTITY_CODE(IDENT), .RATE_BASE(20)) accel_target_inst (.clock(clock), .reset_n(reset_n),
		.link(link), .addr_select(addr_select), .raw_x(raw_x), .raw_y(raw_y), .raw_z(raw_z),
		.main_control(main_control), .data_ready(data_ready), .selftest_active(selftest_active));
	accel_controller #(.QUARTER(2)) accel_controller_inst (.clock(clock), .reset_n(reset_n), .link(link),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_rdata(cmd_rdata));
	accel_link_assertions accel_link_assertions_inst (.clock(clock), .reset_n(reset_n),
		.host_scl_out(link.host_scl_out), .host_scl_oe_n(link.host_scl_oe_n), .host_sda_out(link.host_sda_out),
		.host_sda_oe_n(link.host_sda_oe_n), .dev_scl_out(link.dev_scl_out), .dev_scl_oe_n(link.dev_scl_oe_n),
		.dev_sda_out(link.dev_sda_out), .dev_sda_oe_n(link.dev_sda_oe_n), .scl(link.scl), .sda(link.sda));
	always #5 clock = ~clock;
	task automatic end_of_test();
		if (fail_count == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic cmd_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		cmd_addr <= a;
		cmd_wdata <= d;
		cmd_write <= 1'b1;
		@(posedge clock);
		cmd_write <= 1'b0;
	endtask
	task automatic cmd_rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock);
		cmd_addr <= a;
		cmd_read <= 1'b1;
		@(posedge clock);
		cmd_read <= 1'b0;
		// Read data stand in the cycle after the strobe; take them at the edge that closes it.
		@(posedge clock);
		d = cmd_rdata;
	endtask
	// Runs one bus transfer through the controller; flip names the wrong target.
	task automatic xfer(input logic [7:0] p, input int n, input logic rd, input logic flip, output logic nk);
		logic [7:0] s;
		cmd_wr(HOST_REG_POINTER, p);
		cmd_wr(HOST_REG_LENGTH, 8'(n));
		for (int i = 0; i < n; i++) cmd_wr(HOST_REG_BUFFER + 4'(i), buf_q[i]);
		cmd_wr(HOST_REG_COMMAND, {5'h0, addr_select ^ flip, rd, 1'b1});
		s = 8'h01;
		for (int t = 0; t < 3000 && s[0] !== 1'b0; t++) cmd_rd(HOST_REG_STATUS, s);
		if (s[0] !== 1'b0) begin
			fail_count++;
			end_of_test();
		end
		nk = s[1];
		if (rd) for (int i = 0; i < n; i++) cmd_rd(HOST_REG_BUFFER + 4'(i), buf_q[i]);
	endtask
	// Burst write from a reserved address, then burst read back.
	task automatic s_burst();
		logic nk;
		buf_q = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'h00, 8'h00, 8'h00};
		xfer(8'h1c, 4, 1'b0, 1'b0, nk);
		`CHK(nk, 1'b0)
		xfer(REG_MAIN_CONTROL, 5, 1'b1, 1'b0, nk);
		`CHK(buf_q[1], 8'h00)
		`CHK(buf_q[2], 8'h22)
		`CHK(buf_q[3], 8'h33)
		`CHK(buf_q[4], 8'h44)
	endtask
	// Selftest_control response toggles and clears on read.
	task automatic s_selftest();
		logic nk;
		xfer(REG_SELFTEST_RESPONSE, 1, 1'b1, 1'b0, nk);
		`CHK(buf_q[0], SELFTEST_IDLE)
		buf_q[0] = 8'h10;
		xfer(REG_SELFTEST_CONTROL, 1, 1'b0, 1'b0, nk);
		`CHK(selftest_active, 1'b1)
		xfer(REG_SELFTEST_RESPONSE, 2, 1'b1, 1'b0, nk);
		`CHK(buf_q[0], SELFTEST_DONE)
		xfer(REG_SELFTEST_RESPONSE, 1, 1'b1, 1'b0, nk);
		`CHK(buf_q[0], SELFTEST_IDLE)
	endtask
	// Mode cleared before reconfiguring; e holds the six output bytes, lowest address first.
	task automatic s_axes(input logic [7:0] c, input logic [47:0] e);
		logic nk;
		buf_q[0] = 8'h00;
		xfer(REG_MAIN_CONTROL, 1, 1'b0, 1'b0, nk);
		buf_q[0] = c;
		xfer(REG_MAIN_CONTROL, 1, 1'b0, 1'b0, nk);
		`CHK(main_control, c)
		repeat (60) @(posedge clock);
		`CHK(data_ready, 1'b1)
		xfer(REG_X_LOW, 6, 1'b1, 1'b0, nk);
		for (int i = 0; i < 6; i++) `CHK(buf_q[i], e[8*i+:8])
	endtask
	// Wrong strap bit is not acknowledged; right one reads the identity.
	task automatic s_strap();
		logic nk;
		xfer(REG_DEVICE_IDENTITY, 1, 1'b1, 1'b1, nk);
		`CHK(nk, 1'b1)
		xfer(REG_DEVICE_IDENTITY, 2, 1'b1, 1'b0, nk);
		`CHK(nk, 1'b0)
		`CHK(buf_q[0], IDENT)
		`CHK(buf_q[1], 8'h00)
	endtask
	initial begin
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		raw_x <= 16'sh4000;
		raw_y <= -16'sd16392;
		raw_z <= 16'sh0128;
		s_burst();
		s_selftest();
		s_axes(8'hc0, 48'h0250_8000_7ff0);
		s_axes(8'h88, 48'h0100_bf00_4000);
		s_axes(8'hd0, 48'h0090_dff0_2000);
		addr_select <= 1'b1;
		s_strap();
		end_of_test();
	end
endmodule
`default_nettype wire
